// [include/mse_pkg.sv]
// Package for the miscellaneous sense, enable and cascade block.
// Assumes a single 50 MHz APB clock domain and 32-bit APB data.
//
// Contract
// - Active-low reset clears every register to its reset value.
// - Reset forces mode register bit zero low, selecting stop mode.
// - A sense flag sets when its input stays high 160 ns or longer.
// - A set sense flag stays set until cleared by a register write.
// - Each user output follows its enable bit in the user register.
// - Cascade ready is driven low until cascade mode and JK pair received.
// - Cascade start is the common event that aligns cascaded devices.
package mse_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MSE_OFF_USER_IO = 8'h00;
  localparam logic [7:0] MSE_OFF_MODE    = 8'h04;
  localparam logic [7:0] MSE_OFF_STATUS  = 8'h08;
  localparam logic [7:0] MSE_OFF_MASK    = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         MSE_SENSE_LSB    = 0;   // Sense flags, bits 2:0.
  localparam int         MSE_ENABLE_LSB   = 4;   // Output enable bits, bits 6:4.
  localparam int         MSE_MODE_RUN_BIT = 0;   // Zero means stop mode.
  localparam int         MSE_MODE_CASC_BIT = 1;
  localparam int         MSE_MODE_JK_BIT  = 2;   // Read-only, JK pair seen.
  localparam int         MSE_MODE_CR_BIT  = 3;   // Read-only, ready released.
  localparam int         MSE_MODE_ALN_BIT = 4;   // Read-only, cascade aligned.
  localparam logic [2:0] MSE_ENABLE_RST   = 3'h0;
  localparam logic [1:0] MSE_MODE_RST     = 2'h0;
  localparam logic [3:0] MSE_MASK_RST     = 4'h0;
  localparam int         MSE_EV_ALIGN     = 3;   // Status bit for cascade start.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MSE_CLK_MHZ       = 50;
  localparam int MSE_SENSE_MIN_NS  = 160;
  localparam int MSE_SENSE_CYCLES  = (MSE_SENSE_MIN_NS * MSE_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } mse_apb_req_t;

  typedef enum logic [2:0] {
    MSE_CS_IDLE  = 3'b001,
    MSE_CS_READY = 3'b010,
    MSE_CS_ALIGN = 3'b100
  } mse_casc_st_t;

endpackage

// [hdl/mse_sense_filter.sv]
// One sense input filter: synchroniser, high-time counter, sticky flag.
// Assumes the input is synchronous enough to pclk to be sampled twice.
`timescale 1ns/1ps
module mse_sense_filter #(
  parameter int MIN_CYCLES = mse_pkg::MSE_SENSE_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // Pin and control
  input  wire logic sense_pin,
  input  wire logic clear,
  // Result
  output logic      flag,
  output logic      set_pulse
);

  localparam int CW = $clog2(MIN_CYCLES + 1);

  logic          sync1_r;
  logic          sync2_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          flag_r;
  logic          flag_nxt;
  logic          hit;

  // Count the synchronised high time; a low sample restarts the count.
  always_comb
  begin
    cnt_nxt = cnt_r;
    hit     = 1'b0;
    if (!sync2_r)
      cnt_nxt = '0;
    else if (cnt_r != CW'(MIN_CYCLES))
      cnt_nxt = cnt_r + CW'(1);
    if (sync2_r && (cnt_r == CW'(MIN_CYCLES - 1)))
      hit = 1'b1;
    // Set wins over a clear in the same cycle, so no event is lost.
    flag_nxt = hit | (flag_r & ~clear);
  end

  // Registers; reset clears everything.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r   <= '0;
      flag_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_r <= sense_pin;
      sync2_r <= sync1_r;
      cnt_r   <= cnt_nxt;
      flag_r  <= flag_nxt;
    end
  end

  assign flag      = flag_r;
  assign set_pulse = hit & ~flag_r & clk_en;

endmodule

// [hdl/mse_cascade.sv]
// Cascade ready and start handshake.
// Assumes cascade start is tied low when cascading is unused.
`timescale 1ns/1ps
module mse_cascade (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // Control
  input  wire logic cascade_mode_bit,
  input  wire logic jk_pair_seen,
  input  wire logic cascade_start,
  // Open-drain ready, low enable and status
  output logic      cascade_ready_out_o,
  output logic      cascade_ready_out_oe,
  output logic      aligned,
  output logic      align_pulse
);

  mse_pkg::mse_casc_st_t st_r;
  mse_pkg::mse_casc_st_t st_nxt;
  logic                  start_q_r;
  logic                  rise;

  // Next state; leaving cascade mode always returns to idle.
  always_comb
  begin
    st_nxt = st_r;
    rise   = cascade_start & ~start_q_r;
    case (st_r)
      mse_pkg::MSE_CS_IDLE:
        if (cascade_mode_bit && jk_pair_seen)
          st_nxt = mse_pkg::MSE_CS_READY;
      mse_pkg::MSE_CS_READY:
        if (!cascade_mode_bit)
          st_nxt = mse_pkg::MSE_CS_IDLE;
        else if (rise)
          st_nxt = mse_pkg::MSE_CS_ALIGN;
      mse_pkg::MSE_CS_ALIGN:
        if (!cascade_mode_bit)
          st_nxt = mse_pkg::MSE_CS_IDLE;
      default:
        st_nxt = mse_pkg::MSE_CS_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= mse_pkg::MSE_CS_IDLE;
      start_q_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r      <= st_nxt;
      start_q_r <= cascade_start;
    end
  end

  // Drive the line low in idle; released otherwise. The pin output is always zero.
  assign cascade_ready_out_o  = 1'b0;
  assign cascade_ready_out_oe = (st_r == mse_pkg::MSE_CS_IDLE);
  assign aligned              = (st_r == mse_pkg::MSE_CS_ALIGN);
  assign align_pulse          = clk_en & rise & (st_r == mse_pkg::MSE_CS_READY);

endmodule

// [hdl/mse_top.sv]
// Top of the miscellaneous sense, enable and cascade block with APB slave.
// Assumes APB master signals are synchronous to pclk; pins are sampled on pclk.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module mse_top #(
  parameter int NUM_SENSE = 3
) (
  // Clock, reset and clock enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // APB slave
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // User pins
  input  wire logic [NUM_SENSE-1:0] sense_pin,
  output logic      [NUM_SENSE-1:0] user_output,
  // Cascade
  input  wire logic                 jk_pair_seen,
  input  wire logic                 cascade_start,
  output logic                      cascade_ready_out_o,
  output logic                      cascade_ready_out_oe,
  // Mode and interrupt
  output logic                      run_mode,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  mse_pkg::mse_apb_req_t req;
  logic                  acc;
  logic                  wr;
  logic                  hit_user;
  logic                  hit_mode;
  logic                  hit_stat;
  logic                  hit_mask;
  logic                  mapped;

  // Gather the request; a write lands at the access edge only.
  always_comb
  begin
    req      = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite,
                 pwdata: pwdata};
    acc      = req.psel & req.penable & clk_en;
    wr       = acc & req.pwrite;
    hit_user = (req.paddr == mse_pkg::MSE_OFF_USER_IO);
    hit_mode = (req.paddr == mse_pkg::MSE_OFF_MODE);
    hit_stat = (req.paddr == mse_pkg::MSE_OFF_STATUS);
    hit_mask = (req.paddr == mse_pkg::MSE_OFF_MASK);
    mapped   = hit_user | hit_mode | hit_stat | hit_mask;
  end

  // Zero wait states, but a frozen clock enable stalls the access.
  assign pready  = clk_en;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // Sense filters
  // ----------------------------------------------------------------
  logic [NUM_SENSE-1:0] sense_flag;
  logic [NUM_SENSE-1:0] sense_set;
  logic [NUM_SENSE-1:0] sense_clr;

  // Writing one to a sense bit of the user register clears it.
  assign sense_clr = (wr && hit_user) ? pwdata[mse_pkg::MSE_SENSE_LSB +: NUM_SENSE]
                                      : '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SENSE; gi++)
    begin : g_sense
      mse_sense_filter #(
        .MIN_CYCLES (mse_pkg::MSE_SENSE_CYCLES)
      ) u_filt (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .sense_pin (sense_pin[gi]),
        .clear     (sense_clr[gi]),
        .flag      (sense_flag[gi]),
        .set_pulse (sense_set[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [NUM_SENSE-1:0] enable_r;
  logic [NUM_SENSE-1:0] enable_nxt;
  logic [1:0]           mode_r;
  logic [1:0]           mode_nxt;
  logic [NUM_SENSE:0]   mask_r;
  logic [NUM_SENSE:0]   mask_nxt;
  logic [NUM_SENSE:0]   stat_r;
  logic [NUM_SENSE:0]   stat_nxt;
  logic [NUM_SENSE-1:0] user_output_r;
  logic                 irq_r;
  logic                 aligned;
  logic                 align_pulse;
  logic [NUM_SENSE:0]   events;

  assign events = {align_pulse, sense_set};

  // Next values of the software registers and sticky status.
  always_comb
  begin
    enable_nxt = enable_r;
    mode_nxt   = mode_r;
    mask_nxt   = mask_r;
    if (wr && hit_user)
      enable_nxt = pwdata[mse_pkg::MSE_ENABLE_LSB +: NUM_SENSE];
    if (wr && hit_mode)
      mode_nxt = {pwdata[mse_pkg::MSE_MODE_CASC_BIT], pwdata[mse_pkg::MSE_MODE_RUN_BIT]};
    if (wr && hit_mask)
      mask_nxt = pwdata[NUM_SENSE:0];
    // An event in the clear cycle keeps its bit set.
    stat_nxt = events | (stat_r & ~((wr && hit_stat) ? pwdata[NUM_SENSE:0]
                                                    : {(NUM_SENSE + 1){1'b0}}));
  end

  // Register stage; reset puts the block in stop mode with outputs off.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r      <= mse_pkg::MSE_ENABLE_RST;
      mode_r        <= mse_pkg::MSE_MODE_RST;
      mask_r        <= mse_pkg::MSE_MASK_RST;
      stat_r        <= '0;
      user_output_r <= '0;
      irq_r         <= 1'b0;
    end
    else if (clk_en)
    begin
      enable_r      <= enable_nxt;
      mode_r        <= mode_nxt;
      mask_r        <= mask_nxt;
      stat_r        <= stat_nxt;
      user_output_r <= enable_nxt;
      irq_r         <= |(stat_nxt & mask_nxt);
    end
  end

  assign user_output = user_output_r;
  assign run_mode    = mode_r[0];
  assign irq         = irq_r;

  // ----------------------------------------------------------------
  // Cascade handshake
  // ----------------------------------------------------------------
  mse_cascade u_casc (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_en               (clk_en),
    .cascade_mode_bit     (mode_r[1]),
    .jk_pair_seen         (jk_pair_seen),
    .cascade_start        (cascade_start),
    .cascade_ready_out_o  (cascade_ready_out_o),
    .cascade_ready_out_oe (cascade_ready_out_oe),
    .aligned              (aligned),
    .align_pulse          (align_pulse)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;

  // Read mux; prdata is registered ahead of the access phase edge.
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (hit_user)
    begin
      rd_nxt[mse_pkg::MSE_SENSE_LSB +: NUM_SENSE]  = sense_flag;
      rd_nxt[mse_pkg::MSE_ENABLE_LSB +: NUM_SENSE] = enable_r;
    end
    else if (hit_mode)
    begin
      rd_nxt[mse_pkg::MSE_MODE_RUN_BIT]  = mode_r[0];
      rd_nxt[mse_pkg::MSE_MODE_CASC_BIT] = mode_r[1];
      rd_nxt[mse_pkg::MSE_MODE_JK_BIT]   = jk_pair_seen;
      rd_nxt[mse_pkg::MSE_MODE_CR_BIT]   = ~cascade_ready_out_oe;
      rd_nxt[mse_pkg::MSE_MODE_ALN_BIT]  = aligned;
    end
    else if (hit_stat)
      rd_nxt[NUM_SENSE:0] = stat_r;
    else if (hit_mask)
      rd_nxt[NUM_SENSE:0] = mask_r;
  end

  // Capture in the setup cycle so data stands through the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (clk_en && psel && !penable)
      prdata_r <= rd_nxt;
  end

  assign prdata = prdata_r;

endmodule

// [tb/mse_peer.sv]
// Behavioural cascaded peer for the cascade ready and start handshake.
// Assumes a pull-up on the shared ready line and the bench clock and reset.
`timescale 1ns/1ps
module mse_peer (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Cascade wiring
  input  wire logic peer_arm,
  input  wire logic dut_pull,
  output logic      cascade_start,
  output logic      line_high
);
  logic peer_pull;

  // The pull-up lifts the line only once no device pulls it low.
  assign line_high = !(dut_pull || peer_pull);

  // Start stays low while unarmed, and rises only after the released line is seen.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      peer_pull     <= 1'b1;
      cascade_start <= 1'b0;
    end
    else
    begin
      peer_pull     <= !peer_arm;
      cascade_start <= peer_arm && line_high;
    end
  end
endmodule

// [tb/mse_top_sva.sv]
// Checker for the sense, enable and cascade block, attached by bind.
// Assumes the APB master holds each request until pready is sampled high.
`timescale 1ns/1ps
module mse_top_sva #(
  parameter int NUM_SENSE = 3
) (
  // Clock, reset and APB
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 clk_en,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Pins
  input wire logic [NUM_SENSE-1:0] sense_pin,
  input wire logic [NUM_SENSE-1:0] user_output,
  input wire logic                 jk_pair_seen,
  input wire logic                 cascade_start,
  input wire logic                 cascade_ready_out_o,
  input wire logic                 cascade_ready_out_oe,
  input wire logic                 run_mode,
  input wire logic                 irq
);
  logic wr;

  // A write takes effect only at the completing access edge.
  assign wr = psel && penable && pwrite && pready && clk_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_state: assert property ($rose(presetn) |-> !run_mode && user_output == '0
    && !irq && cascade_ready_out_oe) else $error("state not cleared by reset");
  a_drain_low: assert property (cascade_ready_out_o == 1'b0)
    else $error("ready line driven high");
  a_release_jk: assert property ($fell(cascade_ready_out_oe) |-> $past(jk_pair_seen))
    else $error("ready released without JK pair");
  a_out_follow: assert property (wr && paddr == 8'h00 |=> user_output == $past(pwdata[6:4]))
    else $error("user output does not follow enable bits");
  a_out_hold: assert property ($changed(user_output) |-> $past(wr && paddr == 8'h00))
    else $error("user output changed without write");
  a_run_follow: assert property (wr && paddr == 8'h04 |=> run_mode == $past(pwdata[0]))
    else $error("run mode does not follow mode bit");
  a_mask_quiet: assert property (wr && paddr == 8'h0c && pwdata[3:0] == 4'h0 |=> ##1 !irq)
    else $error("irq high with all events masked");
  a_map_err: assert property (psel && penable |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("bad pslverr");
  a_unmapped_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == '0)
    else $error("unmapped read not zero");
endmodule

bind mse_top mse_top_sva #(.NUM_SENSE(NUM_SENSE)) mse_top_sva_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sense_pin(sense_pin), .user_output(user_output),
  .jk_pair_seen(jk_pair_seen), .cascade_start(cascade_start),
  .cascade_ready_out_o(cascade_ready_out_o), .cascade_ready_out_oe(cascade_ready_out_oe),
  .run_mode(run_mode), .irq(irq));

// [tb/mse_top_bench.sv]
// Self-checking bench: APB master, sense pulses and a cascaded peer.
// Assumes zero-wait APB answers and a 50 MHz clock; all waits are bounded.
`timescale 1ns/1ps
module mse_top_bench;
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, jk = 1'b0, arm = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, slv, cstart, oe, ro, line, run_mode, irq;
  logic [2:0]  sense_pin = 3'h0, user_output, en;
  int          err_count = 0, samples_checked = 0, n, i;

  // ------------------------------------------------------------
  // Clock, design and peer
  // ------------------------------------------------------------
  always #10 pclk = ~pclk;

  mse_top #(.NUM_SENSE(3)) mse_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_pin(sense_pin),
    .user_output(user_output), .jk_pair_seen(jk), .cascade_start(cstart),
    .cascade_ready_out_o(ro), .cascade_ready_out_oe(oe), .run_mode(run_mode), .irq(irq));
  mse_peer mse_peer_inst (.pclk(pclk), .presetn(presetn), .peer_arm(arm), .dut_pull(oe),
    .cascade_start(cstart), .line_high(line));

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task summarize;
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge only.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      summarize();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Sense pin held high for exactly c cycles.
  task pulse(input int p, input int c);
    @(posedge pclk);
    sense_pin[p] <= 1'b1;
    repeat (c) @(posedge pclk);
    sense_pin[p] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task wait_oe(input logic v);
    for (int k = 0; k < 20 && oe !== v; k++) @(posedge pclk);
    chk(oe, v);
  endtask

  function logic [31:0] uio(input logic [2:0] fl, input logic [2:0] e);
    return (32'(e) << mse_pkg::MSE_ENABLE_LSB) | 32'(fl);
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4e96c8e0));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 16; i += 4) rd_chk(8'(i), 32'h0);
    chk(run_mode, 1'b0);
    chk(oe, 1'b1);
    repeat (6)
    begin
      en = 3'($urandom);
      apb(1'b1, 8'h00, uio(3'h0, en));
      @(posedge pclk);
      chk(user_output, en);
      rd_chk(8'h00, uio(3'h0, en));
    end
    // Read-only mode bits ignore writes.
    apb(1'b1, 8'h04, 32'h1d);
    @(posedge pclk);
    chk(run_mode, 1'b1);
    rd_chk(8'h04, 32'h1);
    apb(1'b1, 8'h10, 32'hffffffff);
    chk(slv, 1'b1);
    rd_chk(8'h10, 32'h0);
    chk(slv, 1'b1);
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h0c, 32'(1 << ((i + 1) % 3)));
      pulse(i, 1 + $urandom % 6);
      rd_chk(8'h08, 32'h0);
      pulse(i, 9 + $urandom % 8);
      rd_chk(8'h00, uio(3'(1 << i), en));
      rd_chk(8'h08, 32'(1 << i));
      chk(irq, 1'b0);
      apb(1'b1, 8'h0c, 32'(1 << i));
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, 8'h00, uio(3'(1 << i), en));
      apb(1'b1, 8'h08, 32'(1 << i));
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      rd_chk(8'h00, uio(3'h0, en));
    end
    // A fully masked block keeps irq low.
    apb(1'b1, 8'h0c, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    // A frozen clock enable must also freeze the sense filters.
    clk_en <= 1'b0;
    pulse(0, 12);
    clk_en <= 1'b1;
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h00, uio(3'h0, en));
    apb(1'b1, 8'h04, 32'h3);
    repeat (3) @(posedge pclk);
    chk(oe, 1'b1);
    jk <= 1'b1;
    wait_oe(1'b0);
    rd_chk(8'h04, 32'h0f);
    arm <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(line, 1'b1);
    rd_chk(8'h08, 32'h8);
    rd_chk(8'h04, 32'h1f);
    apb(1'b1, 8'h08, 32'h8);
    apb(1'b1, 8'h04, 32'h1);
    wait_oe(1'b1);
    arm <= 1'b0;
    jk <= 1'b0;
    apb(1'b1, 8'h00, uio(3'h0, 3'h7));
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({user_output, run_mode, oe}, 5'h01);
    presetn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    summarize();
  end

  // Cuts a hang short.
  initial
  begin
    #1500000;
    chk(32'h0, 32'h1);
    summarize();
  end
endmodule
